// ### design/cwp_config_powerup.sv
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module cwp_config_powerup
    import cwp_pkg::*;
#(
    parameter int unsigned POWERUP_DELAY_TIMER_CYCLES = POWERUP_DELAY_TIMER_CYCLES_DEF,
    parameter int unsigned OST_CYCLES  = OST_CYCLES_DEF,
    parameter int unsigned WDT_TICKS   = WDT_TICKS_DEF
)(
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic [11:0]      paddr_i,
    input  wire logic             psel_i,
    input  wire logic             penable_i,
    input  wire logic             pwrite_i,
    input  wire logic [31:0]      pwdata_i,
    output logic      [31:0]      prdata_o,
    output logic                  pready_o,
    output logic                  pslverr_o,
    input  wire logic             prog_mode_i,
    input  wire logic             mclr_n_i,
    input  wire logic             irq_i,
    input  wire logic             wdt_osc_tick_i,
    input  wire logic [CFG_W-1:0] pm_data_i,
    output logic      [CFG_W-1:0] pm_addr_o,
    input  wire logic             ee_write_done_i,
    output logic                  ee_write_start_o,
    output logic                  ee_write_enable_o,
    output logic                  cfgmem_wr_o,
    output logic      [CFG_W-1:0] cfgmem_addr_o,
    output logic      [CFG_W-1:0] cfgmem_data_o,
    output logic                  cpu_reset_o,
    output logic                  powerup_delay_active_o,
    output logic                  program_protect_o,
    output logic                  data_protect_o,
    output logic                  watchdog_enable_o,
    output logic      [1:0]       osc_select_o,
    output logic                  sleep_o,
    output logic                  wdt_reset_o
);
    localparam int unsigned WW = $clog2(WDT_TICKS + 1);

    // ********************************************************************
    // power-up sequencing and eeprom write guard
    // ********************************************************************
    logic             fetch;
    logic             soft_rst;
    logic             acc;
    logic             acc_wr;
    logic             wr_unlock;
    logic             wr_ee_ctrl;
    logic             wr_other;
    logic             ee_busy;
    logic [CFG_W-1:0] cfg;
    logic [CFG_W-1:0] next_cfg;

    cwp_por_seq #(
        .POWERUP_DELAY_TIMER_CYCLES (POWERUP_DELAY_TIMER_CYCLES),
        .OST_CYCLES  (OST_CYCLES)
    ) u_seq (
        .clk_i         (clk_i),
        .rst_n_i       (rst_n_i),
        .soft_rst_i    (soft_rst),
        .cfg_word_i    (pm_data_i),
        .fetch_o       (fetch),
        .hold_reset_o  (cpu_reset_o),
        .powerup_delay_timer_active_o (powerup_delay_active_o)
    );

    cwp_eeprom_guard u_guard (
        .clk_i         (clk_i),
        .rst_n_i       (rst_n_i),
        .unlock_wr_i   (wr_unlock),
        .unlock_data_i (pwdata_i[7:0]),
        .ctrl_wr_i     (wr_ee_ctrl),
        .ctrl_eeprom_write_enable_bit_i   (pwdata_i[EE_EEPROM_WRITE_ENABLE_BIT_BIT]),
        .ctrl_wr_set_i (pwdata_i[EE_WR_BIT]),
        .other_wr_i    (wr_other),
        .powerup_delay_timer_active_i (powerup_delay_active_o),
        .write_done_i  (ee_write_done_i),
        .eeprom_write_enable_bit_o        (ee_write_enable_o),
        .busy_o        (ee_busy),
        .write_start_o (ee_write_start_o)
    );

    // ********************************************************************
    // configuration capture and decode
    // ********************************************************************
    always_comb
    begin
        // sampled only while the sequencer is in its fetch state, i.e. in reset
        next_cfg = fetch ? pm_data_i : cfg;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            cfg               <= CFG_ERASED;
            pm_addr_o         <= CFG_WORD_ADDR;
            program_protect_o <= 1'b0;
            data_protect_o    <= 1'b0;
            watchdog_enable_o <= 1'b1;
            osc_select_o      <= OSC_RESISTOR_CAPACITOR;
        end
        else
        begin
            cfg               <= next_cfg;
            pm_addr_o         <= CFG_WORD_ADDR;
            // a programmed (zero) bit anywhere in either field turns protection on
            program_protect_o <= ~&{next_cfg[CFG_PP_HI_LSB +: 6],
                                    next_cfg[CFG_PP_LO_LSB +: 3]};
            data_protect_o    <= ~next_cfg[CFG_DP_BIT];
            watchdog_enable_o <= next_cfg[CFG_WDT_EN_BIT];
            osc_select_o      <= next_cfg[CFG_OSC_LSB +: 2];
        end
    end

    // ********************************************************************
    // watchdog and sleep
    // ********************************************************************
    logic [WW-1:0] wdt_cnt;
    logic [WW-1:0] next_wdt_cnt;
    logic          wdt_fire;
    logic          wdt_clr;
    logic          sleep_req;
    logic          next_sleep;
    logic          wake;

    always_comb
    begin
        wdt_clr      = acc_wr && paddr_i == REG_CTRL && pwdata_i[CTRL_WDT_CLR_BIT];
        sleep_req    = acc_wr && paddr_i == REG_CTRL && pwdata_i[CTRL_SLEEP_BIT];
        // no register bit can stop it: only the configuration enable and the core reset gate the count
        wdt_fire     = watchdog_enable_o && wdt_osc_tick_i && !cpu_reset_o
                       && wdt_cnt == WW'(WDT_TICKS - 1);
        next_wdt_cnt = wdt_cnt;
        if (!watchdog_enable_o || cpu_reset_o || wdt_clr || wdt_fire)
            next_wdt_cnt = '0;
        else if (wdt_osc_tick_i)
            next_wdt_cnt = wdt_cnt + 1'b1;
        wake       = !mclr_n_i || wdt_fire || irq_i;
        next_sleep = sleep_o ? !wake : (sleep_req && !cpu_reset_o && !wake);
        // a timeout during sleep only wakes; awake it resets the core
        soft_rst   = !mclr_n_i || (wdt_fire && !sleep_o);
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            wdt_cnt     <= '0;
            sleep_o     <= 1'b0;
            wdt_reset_o <= 1'b0;
        end
        else
        begin
            wdt_cnt     <= next_wdt_cnt;
            sleep_o     <= next_sleep;
            wdt_reset_o <= wdt_fire && !sleep_o;
        end
    end

    // ********************************************************************
    // apb slave
    // ********************************************************************
    logic [31:0]      next_prdata;
    logic             next_pready;
    logic             next_pslverr;
    logic [CFG_W-1:0] cfg_addr;
    logic [CFG_W-1:0] next_cfg_addr;
    logic             next_cfgmem_wr;
    logic             cfg_reg;
    logic             addr_ok;

    always_comb
    begin
        acc        = psel_i && penable_i && pready_o;
        acc_wr     = acc && pwrite_i && !pslverr_o;
        wr_unlock  = acc_wr && paddr_i == REG_EE_UNLOCK;
        wr_ee_ctrl = acc_wr && paddr_i == REG_EE_CTRL;
        wr_other   = acc_wr && !wr_unlock && !wr_ee_ctrl;
        cfg_reg    = paddr_i == REG_CFG_ADDR || paddr_i == REG_CFG_DATA;
        addr_ok    = cfg_addr >= CFG_SPACE_LO && cfg_addr <= CFG_SPACE_HI;
        next_pready  = psel_i && penable_i && !pready_o;
        next_pslverr = 1'b0;
        next_prdata  = '0;
        unique case (paddr_i)
            REG_CTRL:      next_prdata[CTRL_SLEEP_BIT] = sleep_o;
            REG_STATUS:    next_prdata = {2'h0, cfg, 7'h00, sleep_o, ee_busy,
                                          powerup_delay_active_o, cpu_reset_o,
                                          watchdog_enable_o, data_protect_o,
                                          program_protect_o, osc_select_o};
            // eeprom control stays usable whatever the protection setting
            REG_EE_CTRL:   next_prdata = {29'h0, ee_write_enable_o, ee_busy, 1'b0};
            REG_EE_UNLOCK: next_prdata = '0;
            REG_CFG_ADDR:  next_prdata = {18'h0, cfg_addr};
            REG_CFG_DATA:  next_prdata = (cfg_addr == CFG_WORD_ADDR) ? {18'h0, cfg} : '0;
            default:       next_pslverr = 1'b1;
        endcase
        // outside programming mode the configuration space is closed
        if (cfg_reg && !prog_mode_i)
            next_pslverr = 1'b1;
        if (paddr_i == REG_CFG_DATA && !addr_ok)
            next_pslverr = 1'b1;
        if (next_pslverr)
            next_prdata = '0;
        next_cfg_addr  = (acc_wr && paddr_i == REG_CFG_ADDR) ? pwdata_i[CFG_W-1:0] : cfg_addr;
        next_cfgmem_wr = acc_wr && paddr_i == REG_CFG_DATA;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            prdata_o      <= '0;
            pready_o      <= 1'b0;
            pslverr_o     <= 1'b0;
            cfg_addr      <= CFG_WORD_ADDR;
            cfgmem_wr_o   <= 1'b0;
            cfgmem_addr_o <= '0;
            cfgmem_data_o <= '0;
        end
        else
        begin
            prdata_o      <= next_prdata;
            pready_o      <= next_pready;
            pslverr_o     <= next_pready && next_pslverr;
            cfg_addr      <= next_cfg_addr;
            cfgmem_wr_o   <= next_cfgmem_wr;
            cfgmem_addr_o <= next_cfgmem_wr ? cfg_addr : cfgmem_addr_o;
            cfgmem_data_o <= next_cfgmem_wr ? pwdata_i[CFG_W-1:0] : cfgmem_data_o;
        end
    end

endmodule

// ### common/cwp_pkg.sv
package cwp_pkg;

    // ********************************************************************
    // timing
    // ********************************************************************
    localparam int unsigned CLK_KHZ          = 50_000;
    localparam int unsigned POWERUP_DELAY_TIMER_MS          = 72;
    localparam int unsigned POWERUP_DELAY_TIMER_CYCLES_DEF  = POWERUP_DELAY_TIMER_MS * CLK_KHZ;
    localparam int unsigned OST_CYCLES_DEF   = 1024;
    localparam int unsigned WDT_TICKS_DEF    = 256;

    // ********************************************************************
    // configuration word
    // ********************************************************************
    localparam int unsigned CFG_W            = 14;
    localparam logic [13:0] CFG_WORD_ADDR    = 14'h2007;
    localparam logic [13:0] CFG_SPACE_LO     = 14'h2000;
    localparam logic [13:0] CFG_SPACE_HI     = 14'h3fff;
    localparam logic [13:0] CFG_ERASED       = 14'h3fff;
    localparam int unsigned CFG_OSC_LSB      = 0;
    localparam int unsigned CFG_WDT_EN_BIT   = 2;
    localparam int unsigned CFG_POWERUP_DELAY_TIMER_N_BIT   = 3;
    localparam int unsigned CFG_PP_LO_LSB    = 4;
    localparam int unsigned CFG_DP_BIT       = 7;
    localparam int unsigned CFG_PP_HI_LSB    = 8;

    typedef enum logic [1:0] {
        OSC_LOW_POWER_CRYSTAL = 2'b00,
        OSC_CRYSTAL_RESONATOR = 2'b01,
        OSC_HIGH_SPEED_CRYSTAL = 2'b10,
        OSC_RESISTOR_CAPACITOR = 2'b11
    } cwp_osc_t;

    // ********************************************************************
    // register map
    // ********************************************************************
    localparam logic [11:0] REG_CTRL         = 12'h000;
    localparam logic [11:0] REG_STATUS       = 12'h004;
    localparam logic [11:0] REG_EE_CTRL      = 12'h008;
    localparam logic [11:0] REG_EE_UNLOCK    = 12'h00c;
    localparam logic [11:0] REG_CFG_ADDR     = 12'h010;
    localparam logic [11:0] REG_CFG_DATA     = 12'h014;
    localparam int unsigned CTRL_SLEEP_BIT   = 0;
    localparam int unsigned CTRL_WDT_CLR_BIT = 1;
    localparam int unsigned EE_WR_BIT        = 1;
    localparam int unsigned EE_EEPROM_WRITE_ENABLE_BIT_BIT      = 2;
    localparam int unsigned STAT_CFG_LSB     = 16;
    localparam logic [7:0]  UNLOCK_KEY1      = 8'h55;
    localparam logic [7:0]  UNLOCK_KEY2      = 8'haa;

    // ********************************************************************
    // state machines
    // ********************************************************************
    typedef enum logic [3:0] {
        SEQ_FETCH = 4'b0001,
        SEQ_POWERUP_DELAY_TIMER  = 4'b0010,
        SEQ_OST   = 4'b0100,
        SEQ_RUN   = 4'b1000
    } cwp_seq_t;

    typedef enum logic [2:0] {
        UL_IDLE  = 3'b001,
        UL_KEY1  = 3'b010,
        UL_ARMED = 3'b100
    } cwp_unlock_t;

    function automatic logic cwp_is_crystal(input logic [1:0] osc);
        return osc != OSC_RESISTOR_CAPACITOR;
    endfunction

endpackage

// ### design/cwp_por_seq.sv
`timescale 1ns/1ps
module cwp_por_seq
    import cwp_pkg::*;
#(
    parameter int unsigned POWERUP_DELAY_TIMER_CYCLES = POWERUP_DELAY_TIMER_CYCLES_DEF,
    parameter int unsigned OST_CYCLES  = OST_CYCLES_DEF
)(
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             soft_rst_i,
    input  wire logic [CFG_W-1:0] cfg_word_i,
    output logic                  fetch_o,
    output logic                  hold_reset_o,
    output logic                  powerup_delay_timer_active_o
);
    localparam int unsigned MAXC = (POWERUP_DELAY_TIMER_CYCLES > OST_CYCLES) ? POWERUP_DELAY_TIMER_CYCLES : OST_CYCLES;
    localparam int unsigned CW   = $clog2(MAXC + 1);

    cwp_seq_t        state;
    cwp_seq_t        next_state;
    logic [CW-1:0]   cnt;
    logic [CW-1:0]   next_cnt;
    logic            por_pending;
    logic            next_por_pending;
    logic            xtal;
    logic            next_xtal;

    always_comb
    begin
        next_state       = state;
        next_cnt         = cnt;
        next_por_pending = por_pending;
        next_xtal        = xtal;
        if (soft_rst_i)
        begin
            next_state = SEQ_FETCH;
            next_cnt   = '0;
        end
        else
        begin
            unique case (state)
                SEQ_FETCH:
                begin
                    next_cnt  = '0;
                    next_xtal = cwp_is_crystal(cfg_word_i[CFG_OSC_LSB +: 2]);
                    // delay timer only after power-on or a reset that comes before it completes or the core first runs, never after later resets
                    if (por_pending && !cfg_word_i[CFG_POWERUP_DELAY_TIMER_N_BIT])
                        next_state = SEQ_POWERUP_DELAY_TIMER;
                    else if (cwp_is_crystal(cfg_word_i[CFG_OSC_LSB +: 2]))
                        next_state = SEQ_OST;
                    else
                        next_state = SEQ_RUN;
                end
                SEQ_POWERUP_DELAY_TIMER:
                begin
                    next_cnt = cnt + 1'b1;
                    if (cnt == CW'(POWERUP_DELAY_TIMER_CYCLES - 1))
                    begin
                        next_cnt         = '0;
                        next_por_pending = 1'b0;
                        next_state       = xtal ? SEQ_OST : SEQ_RUN;
                    end
                end
                SEQ_OST:
                begin
                    next_cnt = cnt + 1'b1;
                    if (cnt == CW'(OST_CYCLES - 1))
                    begin
                        next_cnt   = '0;
                        next_state = SEQ_RUN;
                    end
                end
                SEQ_RUN:
                begin
                    next_por_pending = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            state         <= SEQ_FETCH;
            cnt           <= '0;
            por_pending   <= 1'b1;
            xtal          <= 1'b0;
            hold_reset_o  <= 1'b1;
            powerup_delay_timer_active_o <= 1'b0;
        end
        else
        begin
            state         <= next_state;
            cnt           <= next_cnt;
            por_pending   <= next_por_pending;
            xtal          <= next_xtal;
            hold_reset_o  <= next_state != SEQ_RUN;
            powerup_delay_timer_active_o <= next_state == SEQ_POWERUP_DELAY_TIMER;
        end
    end

    assign fetch_o = state == SEQ_FETCH;

endmodule

// ### design/cwp_eeprom_guard.sv
`timescale 1ns/1ps
module cwp_eeprom_guard
    import cwp_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       unlock_wr_i,
    input  wire logic [7:0] unlock_data_i,
    input  wire logic       ctrl_wr_i,
    input  wire logic       ctrl_eeprom_write_enable_bit_i,
    input  wire logic       ctrl_wr_set_i,
    input  wire logic       other_wr_i,
    input  wire logic       powerup_delay_timer_active_i,
    input  wire logic       write_done_i,
    output logic            eeprom_write_enable_bit_o,
    output logic            busy_o,
    output logic            write_start_o
);
    cwp_unlock_t ul;
    cwp_unlock_t next_ul;
    logic        next_eeprom_write_enable_bit;
    logic        next_busy;
    logic        start;

    always_comb
    begin
        next_ul   = ul;
        next_eeprom_write_enable_bit = eeprom_write_enable_bit_o;
        // any write without a bus error that breaks the 55h/aah/set sequence disarms it
        if (unlock_wr_i)
        begin
            if (ul == UL_IDLE && unlock_data_i == UNLOCK_KEY1)
                next_ul = UL_KEY1;
            else if (ul == UL_KEY1 && unlock_data_i == UNLOCK_KEY2)
                next_ul = UL_ARMED;
            else
                next_ul = UL_IDLE;
        end
        else if (ctrl_wr_i || other_wr_i)
            next_ul = UL_IDLE;
        if (ctrl_wr_i)
            next_eeprom_write_enable_bit = ctrl_eeprom_write_enable_bit_i;
        // uses the enable already set; writing both in one access does not start
        start = ctrl_wr_i && ctrl_wr_set_i && eeprom_write_enable_bit_o && ul == UL_ARMED
                && !powerup_delay_timer_active_i && !busy_o;
        // a new start beats a completion in the same cycle
        next_busy = start ? 1'b1 : (write_done_i ? 1'b0 : busy_o);
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            ul            <= UL_IDLE;
            eeprom_write_enable_bit_o        <= 1'b0;
            busy_o        <= 1'b0;
            write_start_o <= 1'b0;
        end
        else
        begin
            ul            <= next_ul;
            eeprom_write_enable_bit_o        <= next_eeprom_write_enable_bit;
            busy_o        <= next_busy;
            write_start_o <= start;
        end
    end

endmodule

// ### testbench/cwp_prog_model.sv
`timescale 1ns/1ps
module cwp_prog_model
    import cwp_pkg::*;
#(
    parameter logic [CFG_W-1:0] INIT_WORD = 14'h3fff
)(
    input  wire logic             clk_i,
    input  wire logic [CFG_W-1:0] pm_addr_o,
    input  wire logic             cfgmem_wr_o,
    input  wire logic [CFG_W-1:0] cfgmem_addr_o,
    input  wire logic [CFG_W-1:0] cfgmem_data_o,
    output logic      [CFG_W-1:0] pm_data_i
);
    logic [CFG_W-1:0] word = INIT_WORD;
    always @(posedge clk_i)
    begin
        if (cfgmem_wr_o === 1'b1 && cfgmem_addr_o == CFG_WORD_ADDR)
            word <= cfgmem_data_o;
    end
    // other addresses see the inverse, so a stale fetch cannot pass by luck
    always_comb pm_data_i = (pm_addr_o == CFG_WORD_ADDR) ? word : ~word;
endmodule

// ### testbench/cwp_checker.sv
`timescale 1ns/1ps
module cwp_checker
    import cwp_pkg::*;
#(
    parameter int unsigned POWERUP_DELAY_TIMER_CYCLES = 20,
    parameter int unsigned OST_CYCLES  = 8
)(
    input wire logic             clk_i,
    input wire logic             rst_n_i,
    input wire logic             prog_mode_i,
    input wire logic             irq_i,
    input wire logic [CFG_W-1:0] pm_data_i,
    input wire logic             ee_write_start_o,
    input wire logic             ee_write_enable_o,
    input wire logic             cfgmem_wr_o,
    input wire logic             cpu_reset_o,
    input wire logic             powerup_delay_active_o,
    input wire logic             program_protect_o,
    input wire logic             data_protect_o,
    input wire logic             watchdog_enable_o,
    input wire logic [1:0]       osc_select_o,
    input wire logic             sleep_o
);
    logic [31:0] dly_cnt, next_dly_cnt, ost_cnt, next_ost_cnt;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    always_comb
    begin
        next_dly_cnt = powerup_delay_active_o ? dly_cnt + 32'h1 : 32'h0;
        next_ost_cnt = (cpu_reset_o && !powerup_delay_active_o) ? ost_cnt + 32'h1 : 32'h0;
    end
    always_ff @(posedge clk_i)
    begin
        dly_cnt <= rst_n_i ? next_dly_cnt : 32'h0;
        ost_cnt <= rst_n_i ? next_ost_cnt : 32'h0;
    end
    a_cfg_locked: assert property (!$past(prog_mode_i) |-> !cfgmem_wr_o)
        else $error("config space written outside programming mode");
    a_prog_protect: assert property ($fell(cpu_reset_o) |-> program_protect_o ==
        !(&{pm_data_i[13:8], pm_data_i[6:4]})) else $error("program protect decode");
    a_data_protect: assert property ($fell(cpu_reset_o) |-> data_protect_o == !pm_data_i[7])
        else $error("data protect decode");
    a_wdt_decode: assert property ($fell(cpu_reset_o) |-> watchdog_enable_o == pm_data_i[2])
        else $error("watchdog enable decode");
    a_osc_decode: assert property ($fell(cpu_reset_o) |-> osc_select_o == pm_data_i[1:0])
        else $error("oscillator mode decode");
    a_cfg_held: assert property (!cpu_reset_o && !$past(cpu_reset_o) |->
        $stable({program_protect_o, data_protect_o, watchdog_enable_o, osc_select_o}))
        else $error("decoded configuration changed while running");
    a_delay_length: assert property ($fell(powerup_delay_active_o) |-> dly_cnt == POWERUP_DELAY_TIMER_CYCLES)
        else $error("power-up delay length");
    a_osc_settle: assert property ($fell(cpu_reset_o) && osc_select_o != 2'b11 |->
        ost_cnt >= OST_CYCLES) else $error("core released before oscillator settled");
    a_ee_blocked: assert property ($past(powerup_delay_active_o) |-> !ee_write_start_o)
        else $error("eeprom write started during power-up delay");
    a_eeprom_write_enable_bit_cleared: assert property (!$past(rst_n_i) |-> !ee_write_enable_o)
        else $error("write enable not cleared by reset");
    a_irq_wakes: assert property (sleep_o && irq_i |=> !sleep_o)
        else $error("interrupt did not end sleep");
    c_delay_done: cover property ($fell(powerup_delay_active_o));
    c_ee_start: cover property (ee_write_start_o);
    c_wake: cover property (sleep_o && irq_i);
endmodule

// ### testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import cwp_pkg::*;
    localparam int unsigned POWERUP_DELAY_TIMER_C = 20;
    localparam int unsigned WDT_T  = 4;
    logic clk_i = 1'b0, rst_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic prog_mode_i = 1'b0, mclr_n_i = 1'b1, irq_i = 1'b0, wdt_osc_tick_i = 1'b0;
    logic ee_write_done_i = 1'b0, pready_o, pslverr_o, ee_write_start_o, ee_write_enable_o, er;
    logic cfgmem_wr_o, cpu_reset_o, powerup_delay_active_o, program_protect_o, data_protect_o;
    logic watchdog_enable_o, sleep_o, wdt_reset_o;
    logic [11:0]      paddr_i = 12'h000;
    logic [31:0]      pwdata_i = 32'h0, prdata_o, rd;
    logic [CFG_W-1:0] pm_data_i, pm_addr_o, cfgmem_addr_o, cfgmem_data_o;
    logic [1:0]       osc_select_o;
    int miscompares = 0, num_checks = 0, cycles = 0, starts = 0, fires = 0, dly = 0;

    cwp_config_powerup #(.POWERUP_DELAY_TIMER_CYCLES(POWERUP_DELAY_TIMER_C), .OST_CYCLES(8), .WDT_TICKS(WDT_T)) uut (.*);
    cwp_prog_model #(.INIT_WORD(14'h3e75)) prog (.*);

    always #10 clk_i = ~clk_i;

    always @(posedge clk_i)
    begin
        cycles++;
        starts += (ee_write_start_o === 1'b1);
        fires += (wdt_reset_o === 1'b1);
        dly += (powerup_delay_active_o === 1'b1);
        if (cycles > 5000)
        begin
            miscompares++;
            wrap_up();
        end
    end

    task automatic chk(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1)
        begin
            miscompares++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask

    // called right after a rising edge; returns one edge after the handshake
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        n = 0;
        @(posedge clk_i);
        while (pready_o !== 1'b1 && n < 20)
        begin
            @(posedge clk_i);
            n++;
        end
        chk(pready_o === 1'b1, "no bus answer");
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wait_run();
        int n;
        n = 0;
        while (cpu_reset_o !== 1'b0 && n < 500)
        begin
            @(posedge clk_i);
            n++;
        end
        chk(cpu_reset_o === 1'b0, "core stuck in reset");
    endtask

    task automatic tick(input int n);
        repeat (n)
        begin
            wdt_osc_tick_i <= 1'b1;
            @(posedge clk_i);
            wdt_osc_tick_i <= 1'b0;
            @(posedge clk_i);
        end
        repeat (3) @(posedge clk_i);
    endtask

    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk(powerup_delay_active_o === 1'b1, "delay not running");
        apb(1'b1, REG_EE_CTRL, 32'h4);
        apb(1'b1, REG_EE_UNLOCK, 32'h55);
        apb(1'b1, REG_EE_UNLOCK, 32'haa);
        apb(1'b1, REG_EE_CTRL, 32'h6);
        @(posedge clk_i);
        chk(starts == 0, "eeprom write during delay");
        wait_run();
        chk(dly == POWERUP_DELAY_TIMER_C, "delay length");
        apb(1'b0, REG_STATUS, 32'h0);
        chk(rd[5:0] === 6'h1d, "decoded config");
        chk(rd[29:16] === 14'h3e75, "fetched word");
        apb(1'b1, REG_EE_UNLOCK, 32'h55);
        apb(1'b1, REG_EE_UNLOCK, 32'haa);
        apb(1'b1, REG_EE_CTRL, 32'h6);
        @(posedge clk_i);
        chk(starts == 1, "unlocked write did not start");
        apb(1'b0, REG_EE_CTRL, 32'h0);
        chk(rd === 32'h6, "eeprom control readback");
        ee_write_done_i <= 1'b1;
        @(posedge clk_i);
        ee_write_done_i <= 1'b0;
        apb(1'b1, REG_EE_UNLOCK, 32'h55);
        apb(1'b1, REG_EE_UNLOCK, 32'h33);
        apb(1'b1, REG_EE_UNLOCK, 32'haa);
        apb(1'b1, REG_EE_CTRL, 32'h6);
        @(posedge clk_i);
        chk(starts == 1, "broken sequence started a write");
        apb(1'b0, REG_CFG_DATA, 32'h0);
        chk(er === 1'b1, "config space open outside programming");
        apb(1'b0, 12'h020, 32'h0);
        chk(er === 1'b1, "unmapped offset accepted");
        tick(WDT_T);
        chk(fires == 1, "watchdog did not fire");
        wait_run();
        apb(1'b1, REG_CTRL, 32'h1);
        chk(sleep_o === 1'b1, "sleep not entered");
        irq_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk(sleep_o === 1'b0, "interrupt did not wake");
        irq_i <= 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            prog_mode_i <= 1'b1;
            apb(1'b1, REG_CFG_ADDR, 32'h2007);
            apb(1'b1, REG_CFG_DATA, {18'h0, 12'hffe, i[1:0]});
            chk(cfgmem_addr_o === CFG_WORD_ADDR && cfgmem_data_o === {12'hffe, i[1:0]},
                "config write port");
            prog_mode_i <= 1'b0;
            apb(1'b1, REG_CTRL, 32'h1);
            mclr_n_i <= 1'b0;
            repeat (2) @(posedge clk_i);
            mclr_n_i <= 1'b1;
            repeat (2) @(posedge clk_i);
            wait_run();
            chk(sleep_o === 1'b0, "reset did not wake");
            apb(1'b0, REG_STATUS, 32'h0);
            chk(rd[6:0] === {5'h00, i[1:0]}, "oscillator mode");
        end
        tick(WDT_T + 1);
        chk(fires == 1, "disabled watchdog fired");
        chk(dly == POWERUP_DELAY_TIMER_C, "delay after soft reset");
        wrap_up();
    end
endmodule

bind cwp_config_powerup cwp_checker #(.POWERUP_DELAY_TIMER_CYCLES(POWERUP_DELAY_TIMER_CYCLES), .OST_CYCLES(OST_CYCLES)) u_chk (.*);
